// ### design/i2c_nv_config_mux.sv
`timescale 1ns/10ps
module i2c_nv_config_mux (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Two-wire bus, open drain data
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Control and external pins
    input wire nv_mux_pkg::ctl_pins_t ctl_pins,
    // Configuration outputs
    output logic [nv_mux_pkg::MUX_W-1:0] selected_outputs,
    output logic held_config_output
);
    import nv_mux_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisation
    // ----------------------------------------------------------------

    ctl_pins_t pins_s;
    logic [1:0] bus_s;
    logic scl_s;
    logic sda_s;
    logic scl_prev_reg;
    logic sda_prev_reg;

    // Control pins come from outside the clock domain
    pin_sync #(
        .W($bits(ctl_pins_t))
    ) u_ctl_sync (
        .clk(clk),
        .rst(rst),
        .async_in(ctl_pins),
        .sync_out(pins_s)
    );

    // Bus lines come from outside the clock domain
    pin_sync #(
        .W(2)
    ) u_bus_sync (
        .clk(clk),
        .rst(rst),
        .async_in({scl_in, sda_in}),
        .sync_out(bus_s)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    // Previous bus levels for edge and condition detection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    // ----------------------------------------------------------------
    // Bus events
    // ----------------------------------------------------------------

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;

    // Start and stop are data edges while the clock is high
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // ----------------------------------------------------------------
    // Transfer state machine
    // ----------------------------------------------------------------

    xfer_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic rw_reg;
    logic sda_oe_reg;
    logic [7:0] read_byte;
    logic addr_match;
    logic write_ok;
    logic wr_commit;
    logic [NV_W-1:0] nv_reg;

    // Read data: zero top bits, held bit, four muxed bits
    assign read_byte = {RSV_ZERO, nv_reg};

    // Fixed upper bits plus the two address pins
    assign addr_match = (shift_reg[ADDR_MSB:ADDR_FIX_LSB] == ADDR_FIXED) &
        (shift_reg[ADDR_HI_POS] == pins_s.addr_bit_hi) &
        (shift_reg[ADDR_LO_POS] == pins_s.addr_bit_lo);

    // Conditions under which a received byte may be stored
    assign write_ok = ~pins_s.write_protect &
        pins_s.bus_supply_ok & pins_s.supply_ok &
        (shift_reg[RSV_MSB:RSV_LSB] == RSV_ZERO);

    // Store at the fall that begins the data acknowledge
    assign wr_commit = (state_reg == ST_WR_ACK) & scl_fall &
        ~start_seen & ~stop_seen & write_ok;

    // Walks address, acknowledge and one data byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= BIT_FIRST;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            rw_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end
        else if (start_seen)
        begin
            // A start always reopens address reception
            state_reg <= ST_ADDR;
            bit_cnt_reg <= BIT_FIRST;
            sda_oe_reg <= 1'b0;
        end
        else if (stop_seen)
        begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    sda_oe_reg <= 1'b0;
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            state_reg <= ST_ADDR_CHK;
                        end
                    end
                end
                ST_ADDR_CHK:
                begin
                    // Acknowledge only our own address
                    if (scl_fall)
                    begin
                        if (addr_match)
                        begin
                            sda_oe_reg <= 1'b1;
                            rw_reg <= shift_reg[RW_POS];
                            state_reg <= ST_ADDR_ACK;
                        end
                        else
                        begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    // End of acknowledge: start write or first read bit
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= BIT_FIRST;
                        if (rw_reg == RW_READ)
                        begin
                            sda_oe_reg <= ~read_byte[7];
                            tx_reg <= {read_byte[6:0], 1'b0};
                            state_reg <= ST_RD;
                        end
                        else
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_WR;
                        end
                    end
                end
                ST_WR:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == BIT_LAST)
                        begin
                            state_reg <= ST_WR_ACK;
                        end
                    end
                end
                ST_WR_ACK:
                begin
                    // Acknowledge the byte; a refused byte is acknowledged but not stored
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b1;
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_RD:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (bit_cnt_reg == BIT_FIRST)
                        begin
                            // Eight bits sent; release for the answer
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_IGNORE;
                        end
                        else
                        begin
                            sda_oe_reg <= ~tx_reg[7];
                            tx_reg <= {tx_reg[6:0], 1'b0};
                        end
                    end
                end
                ST_IGNORE:
                begin
                    // Drop our acknowledge at the next fall, then wait for a stop or start
                    if (scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;

    // ----------------------------------------------------------------
    // Configuration register
    // ----------------------------------------------------------------

    // Starts at the factory value, updated by an accepted write
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            nv_reg <= NV_RESET;
        end
        else if (wr_commit)
        begin
            nv_reg <= shift_reg[NV_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Output paths
    // ----------------------------------------------------------------

    logic [MUX_W-1:0] sel_next;
    logic held_next;
    logic held_reg;

    // Multiplexed outputs: register, external inputs or forced low
    always_comb
    begin
        if (pins_s.source_select)
        begin
            sel_next = pins_s.external_inputs;
        end
        else if (!pins_s.force_low_n)
        begin
            sel_next = '0;
        end
        else
        begin
            sel_next = nv_reg[MUX_W-1:0];
        end
    end

    // Held output: register bit while select low, zero if also forced low, frozen while high
    always_comb
    begin
        if (pins_s.source_select)
        begin
            held_next = held_reg;
        end
        else if (!pins_s.force_low_n)
        begin
            held_next = 1'b0;
        end
        else
        begin
            held_next = nv_reg[HELD_BIT];
        end
    end

    // Registered multiplexed outputs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            selected_outputs <= '0;
        end
        else
        begin
            selected_outputs <= sel_next;
        end
    end

    // Latch emulation; the held value is the shown output itself
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            held_reg <= 1'b0;
        end
        else
        begin
            held_reg <= held_next;
        end
    end

    assign held_config_output = held_reg;

endmodule

// ### design/nv_mux_pkg.sv
// Summary of operation
// - Select low, force low not asserted: four low register bits drive the selected outputs.
// - Select high: external inputs pass through to the selected outputs.
// - Held output follows its register bit while select low and force low not asserted, holds while high.
// - Held value is what the held output showed when select rose.
// - Force low with select low drives all five outputs low.
// - Register writes are accepted only while write protect is low.
// - The register starts out holding all zeros.
// - Address is 1,0,0,1,1, two address pins, then direction bit.
// - Exactly one data byte follows the address: write or read.
// - Data byte: three zero bits, held bit, then four muxed bits.
// - A write with any of the three top bits set is abandoned.
// - Writes are blocked while bus supply or own supply is not good.
package nv_mux_pkg;

    // ----------------------------------------------------------------
    // Register layout
    // ----------------------------------------------------------------
    localparam int NV_W = 5;
    localparam int MUX_W = 4;
    localparam int HELD_BIT = 4;
    localparam int RSV_LSB = 5;
    localparam int RSV_MSB = 7;
    localparam logic [NV_W-1:0] NV_RESET = 5'h00;
    localparam logic [2:0] RSV_ZERO = 3'h0;

    // ----------------------------------------------------------------
    // Bus framing
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_FIXED = 5'h13;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic RW_READ = 1'b1;
    localparam int ADDR_MSB = 7;
    localparam int ADDR_FIX_LSB = 3;
    localparam int ADDR_HI_POS = 2;
    localparam int ADDR_LO_POS = 1;
    localparam int RW_POS = 0;

    // Slow control pins, sampled together
    typedef struct packed {
        logic source_select;
        logic force_low_n;
        logic write_protect;
        logic bus_supply_ok;
        logic supply_ok;
        logic addr_bit_hi;
        logic addr_bit_lo;
        logic [MUX_W-1:0] external_inputs;
    } ctl_pins_t;

    // Target transfer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_CHK,
        ST_ADDR_ACK,
        ST_WR,
        ST_WR_ACK,
        ST_RD,
        ST_IGNORE
    } xfer_state_t;

endpackage

// ### design/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ### sim/nv_chk_sva.sv
`timescale 1ns/10ps
module nv_chk (
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire nv_mux_pkg::ctl_pins_t ctl_pins,
    input wire logic [nv_mux_pkg::MUX_W-1:0] selected_outputs,
    input wire logic held_config_output
);
    import nv_mux_pkg::*;
    // ----
    // Checks
    // ----
    logic [2:0] age_reg;
    logic sel, frc_n, held;
    assign sel = ctl_pins.source_select;
    assign frc_n = ctl_pins.force_low_n;
    assign held = held_config_output;
    // Cycles since reset, so the pin syncs are flushed
    always_ff @(posedge clk)
    begin
        if (rst)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence sel_rise;
        age_reg == 3'h7 && !sel ##1 sel;
    endsequence
    sequence sel_high_run;
        sel [*5];
    endsequence
    AST_OUT_ZERO: assert property (sda_oe |-> !sda_out)
        else $error("data driven high");
    AST_RESET_CLEAR: assert property ($fell(rst) |->
        !sda_oe && selected_outputs == '0 && !held)
        else $error("outputs not clear after reset");
    AST_MUX_EXT: assert property ((age_reg == 3'h7 && sel &&
        $stable(ctl_pins.external_inputs)) [*4] |->
        selected_outputs == ctl_pins.external_inputs)
        else $error("inputs not passed through");
    AST_FORCE_LOW: assert property ((age_reg == 3'h7 && !sel &&
        !frc_n) [*4] |-> selected_outputs == '0 && !held)
        else $error("force low ignored");
    AST_HELD_STABLE: assert property (((age_reg == 3'h7) and sel_high_run)
        |-> $stable(held))
        else $error("held output moved");
    AST_HELD_FREEZE: assert property (sel_rise ##1 sel_high_run
        |-> held == $past(held, 3))
        else $error("held value not frozen");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved while clock high");
    AST_WP_STABLE: assert property ((age_reg == 3'h7 &&
        ctl_pins.write_protect && !sel && frc_n) [*8] |->
        $stable(selected_outputs) && $stable(held))
        else $error("protected register changed");
endmodule

// ### sim/i2c_ctl_model.sv
`timescale 1ns/10ps
module i2c_ctl_model (
    // Bus lines, data has a pull-up
    output logic scl,
    output logic sda,
    // Target pulls data low
    input wire logic dut_oe
);
    // ----
    // Controller
    // ----
    logic pull_reg = 1'b0;
    logic scl_reg = 1'b1;
    assign scl = scl_reg;
    // Open drain: low if either side pulls
    assign sda = !(pull_reg || dut_oe);
    // One bit: set mid-low, sample mid-high
    task automatic bitx(input logic b, output logic s);
        pull_reg = !b;
        #40;
        scl_reg = 1'b1;
        #40;
        s = sda;
        #40;
        scl_reg = 1'b0;
        #40;
    endtask
    // Data falls while clock high
    task automatic start();
        pull_reg = 1'b1;
        #40;
        scl_reg = 1'b0;
        #40;
    endtask
    // Data rises while clock high, bus left idle
    task automatic stop();
        pull_reg = 1'b1;
        #40;
        scl_reg = 1'b1;
        #40;
        pull_reg = 1'b0;
        #80;
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic mack,
        output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], s);
            q[i] = s;
        end
        bitx(!mack, s);
        ack = !s;
    endtask
endmodule

// ### sim/i2c_nv_config_mux_tb.sv
`timescale 1ns/10ps
module i2c_nv_config_mux_tb;
    import nv_mux_pkg::*;
    // ----
    // Bench
    // ----
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic scl, sda, sda_out, sda_oe, held_o, ak;
    logic [MUX_W-1:0] sel_o;
    ctl_pins_t pins;
    int failures = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'hf4f9acdb;
    logic [31:0] r;
    logic [7:0] exp_q[$];
    logic [7:0] obs, q;
    logic [6:0] dev;
    logic [4:0] v;
    logic [3:0] e;
    event seen;
    initial forever #10 clk = ~clk;
    i2c_nv_config_mux dut_u (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .ctl_pins(pins), .selected_outputs(sel_o),
        .held_config_output(held_o));
    i2c_ctl_model model_u (.scl(scl), .sda(sda), .dut_oe(sda_oe));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        samples_checked++;
        if (got !== want)
        begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, got, want);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Note the expectation, hand the result to the monitor
    task automatic note(input logic [7:0] got, input logic [7:0] want);
        exp_q.push_back(want);
        obs = got;
        -> seen;
    endtask
    initial forever
    begin
        @(seen);
        check(obs, exp_q.pop_front());
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic look(input logic [7:0] want);
        tick(6);
        note({3'h0, held_o, sel_o}, want);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
        input logic ok);
        model_u.start();
        model_u.xfer({a, 1'b0}, 1'b0, q, ak);
        note({7'h0, ak}, {7'h0, ok});
        model_u.xfer(d, 1'b0, q, ak);
        note({7'h0, ak}, {7'h0, ok});
        model_u.stop();
        tick(1);
    endtask
    task automatic rd(input logic [7:0] want);
        model_u.start();
        model_u.xfer({dev, 1'b1}, 1'b0, q, ak);
        note({7'h0, ak}, 8'h01);
        model_u.xfer(8'hff, 1'b0, q, ak);
        note(q, want);
        model_u.stop();
        tick(1);
    endtask
    // Main sequence
    initial
    begin
        r = rnd();
        pins = '0;
        pins.force_low_n = 1'b1;
        pins.bus_supply_ok = 1'b1;
        pins.supply_ok = 1'b1;
        pins.addr_bit_hi = r[1];
        pins.addr_bit_lo = r[0];
        pins.external_inputs = ~r[9:6];
        dev = {ADDR_FIXED, r[1:0]};
        v = {1'b1, r[5:2]};
        e = r[9:6];
        tick(2);
        rst = 1'b0;
        tick(4);
        look(8'h00);
        rd(8'h00);
        wr(dev, {3'h0, v}, 1'b1);
        rd({3'h0, v});
        look({3'h0, v});
        for (int k = 5; k < 8; k++)
        begin
            wr(dev, 8'h01 << k, 1'b1);
            rd({3'h0, v});
        end
        for (int k = 0; k < 4; k++)
        begin
            pins.write_protect = k == 0;
            pins.bus_supply_ok = k != 1;
            pins.supply_ok = k != 2;
            tick(9);
            wr(k == 3 ? dev ^ 7'h01 : dev, 8'h00, k != 3);
            rd({3'h0, v});
        end
        pins.external_inputs = e;
        pins.source_select = 1'b1;
        look({4'h1, e});
        pins.force_low_n = 1'b0;
        look({4'h1, e});
        wr(dev, 8'h05, 1'b1);
        look({4'h1, e});
        pins.force_low_n = 1'b1;
        pins.source_select = 1'b0;
        look(8'h05);
        pins.force_low_n = 1'b0;
        look(8'h00);
        pins.source_select = 1'b1;
        look({4'h0, e});
        pins.force_low_n = 1'b1;
        wr(dev, 8'h1a, 1'b1);
        look({4'h0, e});
        pins.source_select = 1'b0;
        look(8'h1a);
        // Second reset in mid-run: register returns to its factory value
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(4);
        look(8'h00);
        rd(8'h00);
        tick(2);
        report_and_stop();
    end
    // Watchdog, well past the expected run length
    initial
    begin
        #300000;
        failures++;
        report_and_stop();
    end
endmodule
bind i2c_nv_config_mux nv_chk chk_u (.clk(clk), .rst(rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .ctl_pins(ctl_pins),
    .selected_outputs(selected_outputs),
    .held_config_output(held_config_output));
